// ===== hw/count_bank_pkg.sv
package count_bank_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BULK_EP_CTL = 8'hb4;
  localparam logic [7:0] IDX_CTL_EP_RX_COUNT = 8'hb5;
  localparam logic [7:0] IDX_CTL_EP_TX_COUNT = 8'hb6;
  localparam logic [7:0] IDX_INT_EP_RX_COUNT = 8'hb7;
  localparam logic [7:0] IDX_INT_EP_TX_COUNT = 8'hc7;
  localparam logic [7:0] IDX_BULK_A_WR_HIGH = 8'hce;
  localparam logic [7:0] IDX_BULK_A_WR_LOW = 8'hcf;
  localparam logic [7:0] IDX_BULK_B_WR_HIGH = 8'hd1;
  localparam logic [7:0] IDX_BULK_B_WR_LOW = 8'hd2;
  localparam logic [7:0] IDX_BULK_A_RD_HIGH = 8'hd3;
  localparam logic [7:0] IDX_BULK_A_RD_LOW = 8'hd4;
  localparam logic [7:0] IDX_BULK_BUF_CTL = 8'he0;
  localparam logic [7:0] IDX_CTL_EP_TX_CONTROL = 8'he1;
  localparam logic [7:0] IDX_INT_EP_TX_CONTROL = 8'he2;

  // Address decode fields
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int UPPER_LSB = 10;

  // Field positions
  localparam int SMALL_FLAG_BIT = 6;
  localparam int BULK_FLAG_BIT = 1;
  localparam int COUNT_BIT_NINE_POS = 0;
  localparam int STALL_BIT = 2;
  localparam int RD_SEL_BIT = 4;
  localparam int ENABLE_BIT = 0;
  localparam int WR_SEL_BIT = 5;
  localparam int WR_VALID_BIT = 6;
  localparam int RD_VALID_BIT = 1;
  localparam int DIR_BIT = 7;
  localparam int TX_TRIGGER_BIT = 0;

  // Widths
  localparam int SRAM_AW = 11;
  localparam int SMALL_W = 7;
  localparam int BULK_W = 10;

  // Buffer base addresses in SRAM
  localparam logic [10:0] CTL_RX_BASE = 11'h000;
  localparam logic [10:0] CTL_TX_BASE = 11'h040;
  localparam logic [10:0] INT_RX_BASE = 11'h080;
  localparam logic [10:0] INT_TX_BASE = 11'h0c0;
  localparam logic [10:0] BULK_A_BASE = 11'h100;
  localparam logic [10:0] BULK_B_BASE = 11'h300;

  // Reset values
  localparam logic [6:0] SMALL_RESET = 7'h00;
  localparam logic [9:0] BULK_RESET = 10'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Bus encodings
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // Bus slave phases, gray along idle-write-read
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_WRITE = 2'h1,
    PH_READ = 2'h3
  } bus_phase_t;
endpackage : count_bank_pkg

// ===== hw/endpoint_buffer_byte_counts.sv
`timescale 1ns/1ps
// Overview of operation
// - Stall bit 2 stalls both bulk endpoint directions together.
// - Host clearing stall in either direction clears both directions.
// - Bulk endpoint control bit 3 is reserved and reads zero.
// - Control endpoint receive count read-only: bit 6 full, bits 5..0 length.
// - Receive counts load only at transfer end from final SRAM address.
// - Firmware programs control transmit length; device sends it from 0x0040.
// - Zero transmit count with trigger set sends a zero-length packet.
// - Interrupt endpoint receive count read-only, data from 0x0080.
// - SETUP on control endpoint clears interrupt endpoint receive count.
// - Interrupt endpoint transmit count writable, packet fetched from 0x00C0.
// - Bulk buffer A written count: nine bits plus 512 flag, read-only.
// - Bulk buffer B written count: same layout, read-only, data from 0x0300.
// - Reserved bits of count registers always read zero.
// - Buffer A read count high: bit 0 count bit nine, bit 1 full.
// - Selecting write buffer A or B clears that buffer's written counts.
// - Buffer A read count low bits writable, packet from 0x0100.
module endpoint_buffer_byte_counts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire logic [10:0] sie_end_addr,
  input wire logic ctl_rx_done,
  input wire logic int_rx_done,
  input wire logic bulk_wr_done,
  input wire logic setup_rx,
  input wire logic ctl_tx_done,
  input wire logic int_tx_done,
  input wire logic stall_set,
  input wire logic stall_clear_rx,
  input wire logic stall_clear_tx,
  input wire logic bulk_enabled,
  output logic ctl_tx_start,
  output logic [6:0] ctl_tx_len,
  output logic int_tx_start,
  output logic [6:0] int_tx_len,
  output logic bulk_rd_start,
  output logic bulk_rd_buffer,
  output logic [9:0] bulk_rd_len,
  output logic bulk_wr_buffer,
  output logic bulk_dir,
  output logic bulk_stall
);

  count_bank_pkg::bus_phase_t phase;
  logic [7:0] cur_idx;
  logic cur_hit;
  logic take;
  logic wr_strobe;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic [6:0] ctl_rx;
  logic [6:0] int_rx;
  logic [6:0] ctl_tx;
  logic [6:0] int_tx;
  logic [9:0] a_wr;
  logic [9:0] b_wr;
  logic [1:0] a_rd_high;
  logic [7:0] a_rd_low;
  logic ctl_trig;
  logic int_trig;
  logic rd_sel;
  logic stall_write;
  logic stall_clear;
  logic wr_sel_write;
  logic [9:0] bulk_offset;

  // Offset of the buffer end from its base
  function automatic logic [9:0] buf_offset(input logic [10:0] end_addr, input logic [10:0] base);
    logic [10:0] diff;
    diff = end_addr - base;
    return diff[9:0];
  endfunction : buf_offset

  // Write strobe aimed at one register
  function automatic logic wr_to(input logic strobe, input logic [7:0] idx, input logic [7:0] target);
    return strobe && (idx == target);
  endfunction : wr_to

  // Small count from a byte; full flag forces the length bits to zero
  function automatic logic [6:0] small_count(input logic [7:0] b);
    return b[count_bank_pkg::SMALL_FLAG_BIT] ? 7'h40 : {1'b0, b[5:0]};
  endfunction : small_count

  // Address phase acceptance
  assign take = hsel && hready && htrans[1];
  assign wr_strobe = (phase == count_bank_pkg::PH_WRITE) && cur_hit;
  assign wbyte = hwdata[7:0];

  // Bus phase tracking; reads take one wait state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= count_bank_pkg::PH_IDLE;
      hreadyout <= 1'b1;
    end else begin
      unique case (phase)
        count_bank_pkg::PH_IDLE, count_bank_pkg::PH_WRITE: begin
          if (take) begin
            phase <= hwrite ? count_bank_pkg::PH_WRITE : count_bank_pkg::PH_READ;
            hreadyout <= hwrite;
          end else begin
            phase <= count_bank_pkg::PH_IDLE;
          end
        end
        count_bank_pkg::PH_READ: begin
          phase <= count_bank_pkg::PH_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // Captured address; only aligned word addresses below 0x400 hit, mapped or not
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_idx <= count_bank_pkg::BYTE_RESET;
      cur_hit <= 1'b0;
    end else if (take) begin
      cur_idx <= haddr[count_bank_pkg::IDX_MSB:count_bank_pkg::IDX_LSB];
      cur_hit <= (haddr[31:count_bank_pkg::UPPER_LSB] == '0) && (haddr[1:0] == 2'h0);
    end
  end

  // Response is always OKAY
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hresp <= count_bank_pkg::HRESP_OKAY;
    end else begin
      hresp <= count_bank_pkg::HRESP_OKAY;
    end
  end

  // Read multiplexer; reserved bits and unmapped addresses give zero
  always_comb begin
    rd_byte = count_bank_pkg::BYTE_RESET;
    case (cur_idx)
      count_bank_pkg::IDX_BULK_EP_CTL: rd_byte = {3'h0, rd_sel, 1'b0, bulk_stall, 1'b0, bulk_enabled};
      count_bank_pkg::IDX_CTL_EP_RX_COUNT: rd_byte = {1'b0, ctl_rx};
      count_bank_pkg::IDX_CTL_EP_TX_COUNT: rd_byte = {1'b0, ctl_tx};
      count_bank_pkg::IDX_INT_EP_RX_COUNT: rd_byte = {1'b0, int_rx};
      count_bank_pkg::IDX_INT_EP_TX_COUNT: rd_byte = {1'b0, int_tx};
      count_bank_pkg::IDX_BULK_A_WR_HIGH: rd_byte = {6'h00, a_wr[9:8]};
      count_bank_pkg::IDX_BULK_A_WR_LOW: rd_byte = a_wr[7:0];
      count_bank_pkg::IDX_BULK_B_WR_HIGH: rd_byte = {6'h00, b_wr[9:8]};
      count_bank_pkg::IDX_BULK_B_WR_LOW: rd_byte = b_wr[7:0];
      count_bank_pkg::IDX_BULK_A_RD_HIGH: rd_byte = {6'h00, a_rd_high};
      count_bank_pkg::IDX_BULK_A_RD_LOW: rd_byte = a_rd_low;
      count_bank_pkg::IDX_BULK_BUF_CTL: rd_byte = {bulk_dir, 1'b0, bulk_wr_buffer, 5'h00};
      count_bank_pkg::IDX_CTL_EP_TX_CONTROL: rd_byte = {7'h00, ctl_trig};
      count_bank_pkg::IDX_INT_EP_TX_CONTROL: rd_byte = {7'h00, int_trig};
      default: rd_byte = count_bank_pkg::BYTE_RESET;
    endcase
  end

  // Read data registered in the wait state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= count_bank_pkg::WORD_ZERO;
    end else if (phase == count_bank_pkg::PH_READ) begin
      hrdata <= cur_hit ? {24'h000000, rd_byte} : count_bank_pkg::WORD_ZERO;
    end
  end

  // Control endpoint receive count, loaded only at transfer end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_rx <= count_bank_pkg::SMALL_RESET;
    end else if (ctl_rx_done) begin
      ctl_rx <= 7'(buf_offset(sie_end_addr, count_bank_pkg::CTL_RX_BASE));
    end
  end

  // Interrupt endpoint receive count; a finishing transfer wins over SETUP
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_rx <= count_bank_pkg::SMALL_RESET;
    end else if (int_rx_done) begin
      int_rx <= 7'(buf_offset(sie_end_addr, count_bank_pkg::INT_RX_BASE));
    end else if (setup_rx) begin
      int_rx <= count_bank_pkg::SMALL_RESET;
    end
  end

  // Transmit counts written by firmware
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_tx <= count_bank_pkg::SMALL_RESET;
      int_tx <= count_bank_pkg::SMALL_RESET;
    end else begin
      if (wr_to(wr_strobe, cur_idx, count_bank_pkg::IDX_CTL_EP_TX_COUNT)) begin
        ctl_tx <= small_count(wbyte);
      end
      if (wr_to(wr_strobe, cur_idx, count_bank_pkg::IDX_INT_EP_TX_COUNT)) begin
        int_tx <= small_count(wbyte);
      end
    end
  end

  // Control endpoint trigger: start pulse, busy until sent; new trigger wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_trig <= 1'b0;
      ctl_tx_start <= 1'b0;
      ctl_tx_len <= count_bank_pkg::SMALL_RESET;
    end else begin
      ctl_tx_start <= 1'b0;
      if (wr_to(wr_strobe, cur_idx, count_bank_pkg::IDX_CTL_EP_TX_CONTROL) &&
          wbyte[count_bank_pkg::TX_TRIGGER_BIT]) begin
        ctl_trig <= 1'b1;
        ctl_tx_start <= 1'b1;
        ctl_tx_len <= ctl_tx;
      end else if (ctl_tx_done) begin
        ctl_trig <= 1'b0;
      end
    end
  end

  // Interrupt endpoint trigger, same scheme
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_trig <= 1'b0;
      int_tx_start <= 1'b0;
      int_tx_len <= count_bank_pkg::SMALL_RESET;
    end else begin
      int_tx_start <= 1'b0;
      if (wr_to(wr_strobe, cur_idx, count_bank_pkg::IDX_INT_EP_TX_CONTROL) &&
          wbyte[count_bank_pkg::TX_TRIGGER_BIT]) begin
        int_trig <= 1'b1;
        int_tx_start <= 1'b1;
        int_tx_len <= int_tx;
      end else if (int_tx_done) begin
        int_trig <= 1'b0;
      end
    end
  end

  // Stall: one flag covers both directions; any set wins over a host clear
  assign stall_write = wr_to(wr_strobe, cur_idx, count_bank_pkg::IDX_BULK_EP_CTL);
  assign stall_clear = stall_clear_rx || stall_clear_tx;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bulk_stall <= 1'b0;
    end else if (stall_set || (stall_write && wbyte[count_bank_pkg::STALL_BIT])) begin
      bulk_stall <= 1'b1;
    end else if (stall_clear) begin
      bulk_stall <= 1'b0;
    end else if (stall_write) begin
      bulk_stall <= 1'b0;
    end
  end

  // Read buffer select with qualifier; starting A sends buffer A read count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_sel <= 1'b0;
      bulk_rd_start <= 1'b0;
      bulk_rd_buffer <= 1'b0;
      bulk_rd_len <= count_bank_pkg::BULK_RESET;
    end else begin
      bulk_rd_start <= 1'b0;
      if (stall_write && wbyte[count_bank_pkg::RD_VALID_BIT]) begin
        rd_sel <= wbyte[count_bank_pkg::RD_SEL_BIT];
        bulk_rd_start <= 1'b1;
        bulk_rd_buffer <= wbyte[count_bank_pkg::RD_SEL_BIT];
        bulk_rd_len <= wbyte[count_bank_pkg::RD_SEL_BIT] ? count_bank_pkg::BULK_RESET
                                                         : {a_rd_high, a_rd_low};
      end
    end
  end

  // Buffer A read count, firmware written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_rd_high <= 2'h0;
      a_rd_low <= count_bank_pkg::BYTE_RESET;
    end else begin
      if (wr_to(wr_strobe, cur_idx, count_bank_pkg::IDX_BULK_A_RD_HIGH)) begin
        a_rd_high <= wbyte[count_bank_pkg::BULK_FLAG_BIT] ? 2'h2 : {1'b0, wbyte[0]};
        if (wbyte[count_bank_pkg::BULK_FLAG_BIT]) begin
          a_rd_low <= count_bank_pkg::BYTE_RESET;
        end
      end else if (wr_to(wr_strobe, cur_idx, count_bank_pkg::IDX_BULK_A_RD_LOW)) begin
        a_rd_low <= a_rd_high[count_bank_pkg::BULK_FLAG_BIT] ? count_bank_pkg::BYTE_RESET : wbyte;
      end
    end
  end

  // Direction and write buffer select; direction never moves the select
  assign wr_sel_write = wr_to(wr_strobe, cur_idx, count_bank_pkg::IDX_BULK_BUF_CTL);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bulk_dir <= 1'b0;
      bulk_wr_buffer <= 1'b0;
    end else if (wr_sel_write) begin
      bulk_dir <= wbyte[count_bank_pkg::DIR_BIT];
      if (wbyte[count_bank_pkg::WR_VALID_BIT]) begin
        bulk_wr_buffer <= wbyte[count_bank_pkg::WR_SEL_BIT];
      end
    end
  end

  // Bulk written counts: a finishing transfer wins over the select clear
  assign bulk_offset = buf_offset(sie_end_addr, bulk_wr_buffer ? count_bank_pkg::BULK_B_BASE
                                                              : count_bank_pkg::BULK_A_BASE);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_wr <= count_bank_pkg::BULK_RESET;
      b_wr <= count_bank_pkg::BULK_RESET;
    end else if (bulk_wr_done) begin
      if (bulk_wr_buffer) begin
        b_wr <= bulk_offset;
      end else begin
        a_wr <= bulk_offset;
      end
    end else if (wr_sel_write && wbyte[count_bank_pkg::WR_VALID_BIT]) begin
      if (wbyte[count_bank_pkg::WR_SEL_BIT]) begin
        b_wr <= count_bank_pkg::BULK_RESET;
      end else begin
        a_wr <= count_bank_pkg::BULK_RESET;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_stall_both_set: assert property (
    (stall_write && wbyte[count_bank_pkg::STALL_BIT]) |=> bulk_stall [*1])
    else $error("stall bit write did not stall bulk endpoint");

  chk_stall_clear_both: assert property (
    (stall_clear && !stall_set && !stall_write) |=> !bulk_stall)
    else $error("host stall clear left stall set");

  chk_reserved_ctl_bits: assert property (
    (phase == count_bank_pkg::PH_READ && cur_idx == count_bank_pkg::IDX_BULK_EP_CTL)
      |=> (hrdata[3] == 1'b0) && hreadyout)
    else $error("reserved control bit read nonzero");

  chk_ctl_rx_hold: assert property (
    !ctl_rx_done |=> $stable(ctl_rx))
    else $error("control receive count changed without transfer end");

  chk_rx_load: assert property (
    ctl_rx_done |=> ctl_rx == $past(sie_end_addr[6:0]))
    else $error("control receive count not loaded from end address");

  chk_setup_clear: assert property (
    (setup_rx && !int_rx_done) |=> int_rx == count_bank_pkg::SMALL_RESET)
    else $error("setup did not clear interrupt receive count");

  chk_zero_len_send: assert property (
    (ctl_tx == count_bank_pkg::SMALL_RESET && wr_to(wr_strobe, cur_idx, count_bank_pkg::IDX_CTL_EP_TX_CONTROL)
      && wbyte[count_bank_pkg::TX_TRIGGER_BIT]) |=> ctl_tx_start && ctl_tx_len == count_bank_pkg::SMALL_RESET)
    else $error("zero count trigger did not start empty packet");

  chk_tx_len_range: assert property (
    ctl_tx_start |-> (ctl_tx_len <= 7'h40) ##1 !ctl_tx_start)
    else $error("control transmit length out of range");

  chk_wr_select_clear: assert property (
    (wr_sel_write && wbyte[count_bank_pkg::WR_VALID_BIT] && !wbyte[count_bank_pkg::WR_SEL_BIT] && !bulk_wr_done)
      |=> a_wr == count_bank_pkg::BULK_RESET)
    else $error("selecting buffer A did not clear its count");

  chk_bulk_a_load: assert property (
    (bulk_wr_done && !bulk_wr_buffer) |=> a_wr == $past(bulk_offset) && $stable(b_wr))
    else $error("buffer A written count not loaded");

  chk_full_flag_zero: assert property (
    a_wr[9] |-> a_wr[8:0] == 9'h000)
    else $error("full flag with nonzero count");

  chk_read_len_a: assert property (
    (bulk_rd_start && !bulk_rd_buffer) |-> bulk_rd_len == {a_rd_high, a_rd_low})
    else $error("buffer A read length mismatch");

  cov_stall_cycle: cover property (bulk_stall ##[1:20] !bulk_stall);
  cov_zero_len: cover property (ctl_tx_start && ctl_tx_len == count_bank_pkg::SMALL_RESET);
  cov_bulk_full: cover property (bulk_wr_done ##1 a_wr[9]);
  cov_read_wait: cover property (phase == count_bank_pkg::PH_READ ##1 hreadyout);

endmodule : endpoint_buffer_byte_counts

// ===== tb/sie_model.sv
`timescale 1ns/1ps
module sie_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] kind,
  input wire logic go,
  input wire logic [10:0] end_addr,
  input wire logic slow,
  input wire logic ctl_tx_start,
  input wire logic int_tx_start,
  output logic [10:0] sie_end_addr,
  output logic [7:0] strobe,
  output logic ctl_tx_done,
  output logic int_tx_done
);
  logic [3:0] ctl_wait;
  logic [3:0] int_wait;

  // One engine strobe per command; end address valid only with it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe <= 8'h00;
      sie_end_addr <= 11'h7ff;
    end else begin
      strobe <= go ? 8'h01 << kind : 8'h00;
      sie_end_addr <= go ? end_addr : ~sie_end_addr;
    end
  end

  // Packet sent a short or long time after each start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_wait <= 4'h0;
      int_wait <= 4'h0;
    end else begin
      ctl_wait <= ctl_tx_start ? (slow ? 4'h9 : 4'h2) : ctl_wait - (ctl_wait != 4'h0);
      int_wait <= int_tx_start ? (slow ? 4'h9 : 4'h2) : int_wait - (int_wait != 4'h0);
    end
  end

  // Done pulses on the last wait cycle
  assign ctl_tx_done = (ctl_wait == 4'h1);
  assign int_tx_done = (int_wait == 4'h1);
endmodule : sie_model

// ===== tb/test_endpoint_buffer_byte_counts.sv
`timescale 1ns/1ps
module test_endpoint_buffer_byte_counts;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] kind = 3'h0;
  logic go = 1'b0;
  logic [10:0] end_addr = 11'h0;
  logic slow = 1'b0;
  logic bulk_enabled = 1'b0;
  logic hreadyout, ctl_tx_start, int_tx_start, bulk_rd_start, bulk_rd_buffer, bulk_wr_buffer, bulk_dir, bulk_stall;
  logic ctl_tx_done, int_tx_done;
  logic [1:0] hresp;
  logic [31:0] hrdata, rd;
  logic [10:0] sie_end_addr, a, b;
  logic [7:0] strobe, wd;
  logic [6:0] ctl_tx_len, int_tx_len;
  logic [9:0] bulk_rd_len, rl;
  logic [15:0] seed = 16'h002f;
  logic [15:0] bc;
  int bad_count = 0;
  int checks = 0;

  // Core clock, 10 ns period
  always #5 clk = ~clk;

  endpoint_buffer_byte_counts u_endpoint_buffer_byte_counts (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sie_end_addr(sie_end_addr), .ctl_rx_done(strobe[0]), .int_rx_done(strobe[1]),
    .bulk_wr_done(strobe[2]), .setup_rx(strobe[3]), .ctl_tx_done(ctl_tx_done), .int_tx_done(int_tx_done),
    .stall_set(strobe[4]), .stall_clear_rx(strobe[5]), .stall_clear_tx(strobe[6]),
    .bulk_enabled(bulk_enabled), .ctl_tx_start(ctl_tx_start), .ctl_tx_len(ctl_tx_len),
    .int_tx_start(int_tx_start), .int_tx_len(int_tx_len), .bulk_rd_start(bulk_rd_start),
    .bulk_rd_buffer(bulk_rd_buffer), .bulk_rd_len(bulk_rd_len), .bulk_wr_buffer(bulk_wr_buffer),
    .bulk_dir(bulk_dir), .bulk_stall(bulk_stall));

  sie_model u_sie_model (
    .clk(clk), .rst_b(rst_b), .kind(kind), .go(go), .end_addr(end_addr), .slow(slow),
    .ctl_tx_start(ctl_tx_start), .int_tx_start(int_tx_start), .sie_end_addr(sie_end_addr),
    .strobe(strobe), .ctl_tx_done(ctl_tx_done), .int_tx_done(int_tx_done));

  // Linear feedback shift register for stimulus
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Expected small count from bytes received
  function automatic logic [7:0] small_cnt(input logic [10:0] d);
    return (d == 11'h040) ? 8'h40 : {2'h0, d[5:0]};
  endfunction : small_cnt

  // Expected bulk count, high byte over low byte
  function automatic logic [15:0] bulk_cnt(input logic [10:0] d);
    return (d == 11'h200) ? 16'h0200 : {7'h0, d[8:0]};
  endfunction : bulk_cnt

  // Stored transmit count for a written byte
  function automatic logic [7:0] tx_exp(input logic [7:0] w);
    return w[6] ? 8'h40 : {2'h0, w[5:0]};
  endfunction : tx_exp

  function automatic logic sig(input int w);
    case (w)
      0: return hreadyout;
      1: return ctl_tx_start;
      2: return int_tx_start;
      default: return bulk_rd_start;
    endcase
  endfunction : sig

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Bounded wait until a signal will be sampled high, then pass that edge
  task automatic wait_hi(input int w);
    int n;
    n = 0;
    @(negedge clk);
    while (sig(w) !== 1'b1) begin
      n++;
      if (n > 12) begin
        bad_count++;
        final_report();
      end
      @(negedge clk);
    end
    rd = hrdata;
    @(posedge clk);
  endtask : wait_hi

  // One single-word transfer, address then data phase
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wait_hi(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_hi(0);
  endtask : bus

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(name, exp, rd);
    chk("hresp", 32'h0, {30'h0, hresp});
  endtask : rdchk

  // One engine event through the far-side model
  task automatic eng(input logic [2:0] k, input logic [10:0] ea);
    kind <= k;
    end_addr <= ea;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : eng

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdchk("rst ctl rx", 8'hb5, 32'h0);
    rdchk("rst int tx", 8'hc7, 32'h0);
    rdchk("rst a hi", 8'hce, 32'h0);
    rdchk("rst b lo", 8'hd2, 32'h0);
    rdchk("rst rd hi", 8'hd3, 32'h0);
    rdchk("unmapped", 8'h10, 32'h0);
    bus(1'b1, 8'he0, 8'h80);
    bus(1'b1, 8'he0, 8'hc0);
    @(posedge clk);
    chk("dir", 32'h1, {31'h0, bulk_dir});
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      slow <= seed[3];
      bulk_enabled <= seed[2];
      a = (i == 0) ? 11'h040 : {5'h0, seed[5:0]};
      eng(3'h0, a);
      rdchk("ctl rx", 8'hb5, small_cnt(a));
      bus(1'b1, 8'hb5, 8'hff);
      rdchk("ctl rx ro", 8'hb5, small_cnt(a));
      eng(3'h1, 11'h080 + a);
      rdchk("int rx", 8'hb7, small_cnt(a));
      eng(3'h3, 11'h000);
      rdchk("setup clr", 8'hb7, 32'h0);
      wd = (i == 1) ? 8'h00 : (i == 2) ? 8'hff : seed[15:8];
      bus(1'b1, 8'hb6, wd);
      rdchk("ctl tx cnt", 8'hb6, tx_exp(wd));
      bus(1'b1, 8'he1, 8'h01);
      wait_hi(1);
      chk("ctl tx len", tx_exp(wd), {25'h0, ctl_tx_len});
      bus(1'b1, 8'hc7, ~wd);
      rdchk("int tx cnt", 8'hc7, tx_exp(~wd));
      bus(1'b1, 8'he2, 8'h01);
      wait_hi(2);
      chk("int tx len", tx_exp(~wd), {25'h0, int_tx_len});
      b = (i == 0) ? 11'h200 : {2'h0, seed[8:0]};
      bc = bulk_cnt(b);
      bus(1'b1, 8'he0, 8'h40);
      eng(3'h2, 11'h100 + b);
      rdchk("a hi", 8'hce, {24'h0, bc[15:8]});
      rdchk("a lo", 8'hcf, {24'h0, bc[7:0]});
      bus(1'b1, 8'he0, 8'h60);
      @(posedge clk);
      chk("wr buf", 32'h1, {31'h0, bulk_wr_buffer});
      eng(3'h2, 11'h300 + b);
      rdchk("b hi", 8'hd1, {24'h0, bc[15:8]});
      rdchk("b lo", 8'hd2, {24'h0, bc[7:0]});
      bus(1'b1, 8'he0, 8'h40);
      rdchk("a clr", 8'hcf, 32'h0);
      rdchk("b kept", 8'hd2, {24'h0, bc[7:0]});
      rl = seed[11] ? 10'h200 : {seed[10], seed[7:0]};
      bus(1'b1, 8'hd3, {6'h3f, seed[11:10]});
      bus(1'b1, 8'hd4, seed[7:0]);
      rdchk("rd hi", 8'hd3, {30'h0, rl[9:8]});
      bus(1'b1, 8'hb4, 8'h02);
      wait_hi(3);
      chk("rd len", {22'h0, rl}, {22'h0, bulk_rd_len});
      chk("rd buf", 32'h0, {31'h0, bulk_rd_buffer});
      bus(1'b1, 8'hb4, 8'h0c);
      @(posedge clk);
      chk("stall set", 32'h1, {31'h0, bulk_stall});
      rdchk("bulk ctl", 8'hb4, {29'h0, 2'h2, bulk_enabled});
      eng(seed[4] ? 3'h5 : 3'h6, 11'h000);
      chk("stall clr", 32'h0, {31'h0, bulk_stall});
      eng(3'h4, 11'h000);
      chk("stall eng", 32'h1, {31'h0, bulk_stall});
      bus(1'b1, 8'hb4, 8'h00);
      bus(1'b1, 8'hb4, 8'h12);
      wait_hi(3);
      chk("rd buf b", 32'h1, {31'h0, bulk_rd_buffer});
      chk("rd len b", 32'h0, {22'h0, bulk_rd_len});
      bus(1'b1, 8'hb4, 8'h00);
      rdchk("rd sel", 8'hb4, {27'h0, 1'b1, 3'h0, bulk_enabled});
    end
    final_report();
  end
endmodule : test_endpoint_buffer_byte_counts
